// ---- bpsp_pkg.sv ----
/*
  Shared constants for the byte port with slave mode: register offsets,
  field positions, reset values and strobe timing.
  Assumes both ends and the testbench import it.
*/
package bpsp_pkg;
  localparam logic [7:0] BPSP_OFF_DATA = 8'h08;
  localparam logic [7:0] BPSP_OFF_DIR = 8'h88;
  localparam logic [7:0] BPSP_OFF_CTRL = 8'h89;
  localparam logic [7:0] BPSP_OFF_CPIN = 8'h09;
  localparam logic [7:0] BPSP_OFF_ANCFG = 8'h9F;
  localparam int BPSP_BIT_IBF = 7;
  localparam int BPSP_BIT_OBF = 6;
  localparam int BPSP_BIT_OVR = 5;
  localparam int BPSP_BIT_MODE = 4;
  localparam logic [7:0] BPSP_DIR_RST = 8'hFF;
  localparam logic [2:0] BPSP_CDIR_RST = 3'h7;
  localparam logic [2:0] BPSP_ANCFG_RST = 3'h0;
  localparam logic [2:0] BPSP_ANCFG_DIGITAL = 3'h7;
  // completion flag rises this many core cycles plus one after the strobe rises
  localparam int BPSP_DONE_DLY = 2;
  // host holds each strobe level this many cycles
  localparam int BPSP_STROBE_CYC = 4;
endpackage

// ---- bpsp_if.sv ----
/*
  Link between the slave-mode device and an external 8-bit master.
  Assumes the testbench resolves the shared byte wire from both enables.
*/
`timescale 1ns/100ps
interface bpsp_if;
  logic [7:0] dev_data_o;
  logic [7:0] dev_data_oe;
  logic [7:0] host_data_o;
  logic [7:0] host_data_oe;
  logic [7:0] data_lvl;
  logic [2:0] dev_ctl_o;
  logic [2:0] dev_ctl_oe;
  logic rd_n;
  logic wr_n;
  logic cs_n;
  logic [2:0] ctl_lvl;
  modport dev(output dev_data_o, dev_data_oe, dev_ctl_o, dev_ctl_oe, input data_lvl, ctl_lvl);
  modport host(output host_data_o, host_data_oe, rd_n, wr_n, cs_n, input data_lvl);
endinterface

// ---- bpsp_host.sv ----
/*
  External master end: issues single byte writes and reads over the strobes.
  Assumes the device has been put in slave mode by its own software.
*/
`timescale 1ns/100ps
module bpsp_host
  import bpsp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic req_wr_i,
  input wire logic [7:0] req_data_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rd_data_o,
  bpsp_if.host link
);
  typedef enum logic [1:0] {BPH_IDLE = 2'b00, BPH_LOW = 2'b01, BPH_HIGH = 2'b10} bph_state_e;
  bph_state_e state;
  logic is_wr;
  logic [7:0] cnt;

  // ==========================================================
  // strobe sequencer
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= BPH_IDLE;
      is_wr <= 1'b0;
      cnt <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      rd_data_o <= 8'h00;
      link.cs_n <= 1'b1;
      link.rd_n <= 1'b1;
      link.wr_n <= 1'b1;
      link.host_data_o <= 8'h00;
      link.host_data_oe <= 8'h00;
    end else begin
      done_o <= 1'b0;
      unique case (state)
        BPH_IDLE: begin
          if (req_i) begin
            state <= BPH_LOW;
            is_wr <= req_wr_i;
            busy_o <= 1'b1;
            cnt <= 8'h00;
            link.cs_n <= 1'b0;
            link.wr_n <= !req_wr_i;
            link.rd_n <= req_wr_i;
            link.host_data_o <= req_data_i;
            link.host_data_oe <= req_wr_i ? 8'hFF : 8'h00;
          end
        end
        BPH_LOW: begin
          cnt <= cnt + 8'h01;
          if (cnt == 8'(BPSP_STROBE_CYC - 1)) begin
            if (!is_wr) begin
              rd_data_o <= link.data_lvl;
            end
            link.cs_n <= 1'b1;
            link.rd_n <= 1'b1;
            link.wr_n <= 1'b1;
            link.host_data_oe <= 8'h00;
            state <= BPH_HIGH;
            cnt <= 8'h00;
          end
        end
        BPH_HIGH: begin
          cnt <= cnt + 8'h01;
          if (cnt == 8'(BPSP_STROBE_CYC - 1)) begin
            state <= BPH_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end
        default: state <= BPH_IDLE;
      endcase
    end
  end
endmodule

// ---- bpsp_dev.sv ----
/*
  Device end: 8-bit byte port, 3-pin control port and parallel slave mode,
  with the control/status register, reached over a simple core register port.
  Assumes core register accesses are single-cycle strobes synchronous to clk.
*/
// Overview of operation
// - byte port pins each have a direction bit
// - mode bit 4 turns byte port slave
// - three control pins each individually directed
// - slave mode uses control pins as strobes
// - software sets control pins input and digital
// - analog-selected control pins read as zero
// - direction bits still drive analog control pins
// - power-on leaves control pins analog, reading zero
// - read strobe low with select drives latch
// - select low enables transfers, high deselects
// - bit 7 set when input byte unread
// - bit 6 set until master reads output
// - bit 5 set on overwrite, software clears
// - bit 4 selects slave mode, resets zero
// - bit 3 always reads zero
// - bits 2:0 control directions, reset one
// - input-full and done flag set after strobe rises
// - input-full cleared by internal read or by leaving slave mode
// - master read clears output-full at once
// - outside slave mode full flags held clear
`timescale 1ns/100ps
module bpsp_dev
  import bpsp_pkg::*;
#(
  parameter int DONE_DLY = BPSP_DONE_DLY
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic transfer_done_flag_o,
  input wire logic transfer_done_clr_i,
  bpsp_if.dev link
);
  logic [7:0] out_latch;
  logic [7:0] in_latch;
  logic [7:0] byte_port_direction;
  logic [2:0] cpin_dir;
  logic [2:0] cpin_latch;
  logic [2:0] analog_pin_config;
  logic slave_mode_select;
  logic input_full_flag;
  logic output_full_flag;
  logic input_overrun_flag;
  logic wr_act;
  logic rd_act;
  logic [3:0] wr_dly;
  logic [3:0] rd_dly;
  logic [7:0] next_rdata;
  logic [2:0] cpin_read;
  logic cpin_analog;
  logic rd_hit;
  logic wr_hit;
  logic in_read;
  logic ext_wr;
  logic ext_rd;
  logic wr_done;
  logic rd_done;

  // analog unless every config bit is set to digital
  assign cpin_analog = (analog_pin_config != BPSP_ANCFG_DIGITAL);
  assign cpin_read = cpin_analog ? 3'h0 : link.ctl_lvl;
  assign ext_wr = slave_mode_select && !link.ctl_lvl[2] && !link.ctl_lvl[1];
  assign ext_rd = slave_mode_select && !link.ctl_lvl[2] && !link.ctl_lvl[0];
  assign wr_hit = reg_wr_i;
  assign rd_hit = reg_rd_i;
  assign in_read = rd_hit && (reg_addr_i == BPSP_OFF_DATA) && slave_mode_select;
  assign wr_done = wr_dly[DONE_DLY - 1];
  assign rd_done = rd_dly[DONE_DLY - 1];

  // ==========================================================
  // register write side
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_latch <= 8'h00;
      byte_port_direction <= BPSP_DIR_RST;
      cpin_dir <= BPSP_CDIR_RST;
      cpin_latch <= 3'h0;
      analog_pin_config <= BPSP_ANCFG_RST;
      slave_mode_select <= 1'b0;
    end else if (wr_hit) begin
      unique case (reg_addr_i)
        BPSP_OFF_DATA: out_latch <= reg_wdata_i;
        BPSP_OFF_DIR: byte_port_direction <= reg_wdata_i;
        BPSP_OFF_CTRL: begin
          slave_mode_select <= reg_wdata_i[BPSP_BIT_MODE];
          cpin_dir <= reg_wdata_i[2:0];
        end
        BPSP_OFF_CPIN: cpin_latch <= reg_wdata_i[2:0];
        BPSP_OFF_ANCFG: analog_pin_config <= reg_wdata_i[2:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // slave transfers: capture, completion delay, status flags
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_act <= 1'b0;
      rd_act <= 1'b0;
      wr_dly <= 4'h0;
      rd_dly <= 4'h0;
      in_latch <= 8'h00;
    end else begin
      wr_act <= ext_wr;
      rd_act <= ext_rd;
      // strobe end starts a short delay, standing in for the core phase wait
      wr_dly <= {wr_dly[2:0], wr_act && !ext_wr};
      rd_dly <= {rd_dly[2:0], rd_act && !ext_rd};
      if (ext_wr) begin
        in_latch <= link.data_lvl;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      input_full_flag <= 1'b0;
      output_full_flag <= 1'b0;
      input_overrun_flag <= 1'b0;
      transfer_done_flag_o <= 1'b0;
    end else begin
      if (!slave_mode_select) begin
        input_full_flag <= 1'b0;
        output_full_flag <= 1'b0;
      end else begin
        if (wr_done) begin
          input_full_flag <= 1'b1;
        end else if (in_read) begin
          input_full_flag <= 1'b0;
        end
        // a refill landing with a read start wins, so the new byte is not lost
        if (wr_hit && reg_addr_i == BPSP_OFF_DATA) begin
          output_full_flag <= 1'b1;
        end else if (ext_rd && !rd_act) begin
          output_full_flag <= 1'b0;
        end
      end
      // overwrite counted at the start of a write while the old byte is unread
      if (ext_wr && !wr_act && input_full_flag) begin
        input_overrun_flag <= 1'b1;
      end else if (wr_hit && reg_addr_i == BPSP_OFF_CTRL && !reg_wdata_i[BPSP_BIT_OVR]) begin
        input_overrun_flag <= 1'b0;
      end
      if (wr_done || rd_done) begin
        transfer_done_flag_o <= 1'b1;
      end else if (transfer_done_clr_i) begin
        transfer_done_flag_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // pin drive
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link.dev_data_o <= 8'h00;
      link.dev_data_oe <= 8'h00;
      link.dev_ctl_o <= 3'h0;
      link.dev_ctl_oe <= 3'h0;
    end else begin
      link.dev_data_o <= out_latch;
      if (slave_mode_select) begin
        link.dev_data_oe <= ext_rd ? 8'hFF : 8'h00;
      end else begin
        link.dev_data_oe <= ~byte_port_direction;
      end
      link.dev_ctl_o <= cpin_latch;
      link.dev_ctl_oe <= ~cpin_dir;
    end
  end

  // ==========================================================
  // register read side
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr_i)
      BPSP_OFF_DATA: next_rdata = slave_mode_select ? in_latch : link.data_lvl;
      BPSP_OFF_DIR: next_rdata = byte_port_direction;
      BPSP_OFF_CTRL: next_rdata = {input_full_flag, output_full_flag, input_overrun_flag,
                                   slave_mode_select, 1'b0, cpin_dir};
      BPSP_OFF_CPIN: next_rdata = {5'h00, cpin_read};
      BPSP_OFF_ANCFG: next_rdata = {5'h00, analog_pin_config};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (rd_hit) begin
      reg_rdata_o <= next_rdata;
    end
  end
endmodule

// ---- bpsp_assertions.sv ----
/*
  Link checker for the byte port with slave mode.
  Assumes tb instantiates it beside the interface joining both ends.
*/
`timescale 1ns/100ps
module bpsp_assertions (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [7:0] dev_data_o,
  input wire logic [7:0] dev_data_oe,
  input wire logic [7:0] host_data_oe,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cs_n
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  property p_excl; !(!rd_n && !wr_n); endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_wr_sel; !wr_n |-> !cs_n; endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("write without select");
  property p_rd_sel; !rd_n |-> !cs_n; endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("read without select");
  property p_wr_len; $fell(wr_n) |-> (!wr_n)[*4] ##1 wr_n; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe length");
  property p_rd_len; $fell(rd_n) |-> (!rd_n)[*4] ##1 rd_n; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length");
  property p_host_drv; !wr_n |-> host_data_oe == 8'hFF; endproperty
  a_host_drv: assert property (p_host_drv) else $error("host not driving write");
  property p_no_clash; (dev_data_oe & host_data_oe) == 8'h00; endproperty
  a_no_clash: assert property (p_no_clash) else $error("byte wire driven twice");
  property p_rd_hold; !rd_n && !$past(rd_n) && dev_data_oe == 8'hFF |-> $stable(dev_data_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rd_rel; $rose(rd_n) && $past(dev_data_oe) == 8'hFF |-> ##[1:2] dev_data_oe == 8'h00; endproperty
  a_rd_rel: assert property (p_rd_rel) else $error("device kept the wire");
  c_wr: cover property ($fell(wr_n));
  c_rd: cover property ($fell(rd_n));
  c_drv: cover property (!rd_n && dev_data_oe == 8'hFF);
endmodule

// ---- tb.sv ----
/*
  Testbench joining device and master ends over the link.
  Assumes the package and interface are compiled first.
*/
`timescale 1ns/100ps
module tb;
  import bpsp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic clr = 1'b0;
  logic req_i = 1'b0;
  logic req_wr_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] req_data_i = 8'h00;
  logic [7:0] pat = 8'h00;
  logic [7:0] rdata, hdata, d, b;
  logic flag, busy, hdone;
  integer err_total = 0, compares = 0, seed = 12, i;
  logic [7:0] q[$];
  bpsp_if bi();
  // undriven wire bits wander so a stale value never passes
  assign bi.data_lvl = (bi.dev_data_o & bi.dev_data_oe) | (bi.host_data_o & bi.host_data_oe) |
    (pat & ~bi.dev_data_oe & ~bi.host_data_oe);
  assign bi.ctl_lvl = (bi.dev_ctl_o & bi.dev_ctl_oe) | ({bi.cs_n, bi.wr_n, bi.rd_n} & ~bi.dev_ctl_oe);
  bpsp_dev u_bpsp_dev (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata), .transfer_done_flag_o(flag),
    .transfer_done_clr_i(clr), .link(bi.dev));
  bpsp_host u_bpsp_host (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_i(req_i), .req_wr_i(req_wr_i),
    .req_data_i(req_data_i), .busy_o(busy), .done_o(hdone), .rd_data_o(hdata), .link(bi.host));
  bpsp_assertions u_bpsp_assertions (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .dev_data_o(bi.dev_data_o),
    .dev_data_oe(bi.dev_data_oe), .host_data_oe(bi.host_data_oe), .rd_n(bi.rd_n), .wr_n(bi.wr_n), .cs_n(bi.cs_n));
  // ==========================================
  // tasks
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rw(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rr(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic clr_done();
    @(posedge clk_sys_i);
    clr <= 1'b1;
    @(posedge clk_sys_i);
    clr <= 1'b0;
    #1 chk("done cleared", 8'h00, {7'h00, flag});
  endtask
  task automatic xfer(input logic w, input logic [7:0] v);
    integer n;
    @(posedge clk_sys_i);
    req_i <= 1'b1;
    req_wr_i <= w;
    req_data_i <= v;
    @(posedge clk_sys_i);
    req_i <= 1'b0;
    for (n = 0; n < 20 && hdone !== 1'b1; n++) begin
      @(posedge clk_sys_i);
      #1;
    end
    if (hdone !== 1'b1) begin
      err_total++;
      $display("MISMATCH host done expected 1 seen 0");
      wrap_up();
    end
  endtask
  // ==========================================
  // stimulus
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) pat <= pat + 8'h35;
  initial begin
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rr(BPSP_OFF_CTRL, 8'h07, "ctrl reset");
    rr(BPSP_OFF_DIR, BPSP_DIR_RST, "dir reset");
    rr(BPSP_OFF_CPIN, 8'h00, "analog pins");
    rw(BPSP_OFF_DIR, 8'h5A);
    repeat (2) @(posedge clk_sys_i);
    chk("pin enables", 8'hA5, bi.dev_data_oe);
    d = 8'($random(seed));
    rw(BPSP_OFF_DIR, 8'h00);
    rw(BPSP_OFF_DATA, d);
    repeat (3) @(posedge clk_sys_i);
    rr(BPSP_OFF_DATA, d, "port pins");
    rr(BPSP_OFF_CTRL, 8'h07, "port mode flags");
    rw(BPSP_OFF_DIR, 8'hFF);
    rw(BPSP_OFF_ANCFG, {5'h00, BPSP_ANCFG_DIGITAL});
    rr(BPSP_OFF_CPIN, 8'h07, "digital pins");
    rw(BPSP_OFF_CTRL, 8'h17);
    rr(BPSP_OFF_CTRL, 8'h17, "slave mode");
    $display("test port mode done");
    for (i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      xfer(1'b1, d);
      q.push_back(d);
      repeat (3) @(posedge clk_sys_i);
      chk("done flag", 8'h01, {7'h00, flag});
      rr(BPSP_OFF_CTRL, 8'h97, "input full");
      rr(BPSP_OFF_DATA, q.pop_front(), "written byte");
      rr(BPSP_OFF_CTRL, 8'h17, "input read");
      clr_done();
    end
    b = 8'($random(seed));
    xfer(1'b1, d);
    xfer(1'b1, b);
    rr(BPSP_OFF_CTRL, 8'hB7, "overrun");
    rr(BPSP_OFF_DATA, b, "overrun byte");
    rr(BPSP_OFF_CTRL, 8'h37, "overrun kept");
    rw(BPSP_OFF_CTRL, 8'h17);
    rr(BPSP_OFF_CTRL, 8'h17, "overrun cleared");
    $display("test slave write done");
    for (i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      rw(BPSP_OFF_DATA, d);
      rr(BPSP_OFF_CTRL, 8'h57, "output full");
      clr_done();
      xfer(1'b0, 8'h00);
      chk("master read", d, hdata);
      chk("read done flag", 8'h01, {7'h00, flag});
      rr(BPSP_OFF_CTRL, 8'h17, "output read");
    end
    xfer(1'b1, d);
    rw(BPSP_OFF_DATA, b);
    rw(BPSP_OFF_CTRL, 8'h07);
    rr(BPSP_OFF_CTRL, 8'h07, "flags held clear");
    rw(BPSP_OFF_CPIN, 8'h05);
    rw(BPSP_OFF_CTRL, 8'h00);
    rr(BPSP_OFF_CPIN, 8'h05, "driven pins");
    rr(BPSP_OFF_CTRL, 8'h00, "pin outputs");
    rw(BPSP_OFF_ANCFG, 8'h00);
    rr(BPSP_OFF_CPIN, 8'h00, "analog driven pins");
    $display("test slave read done");
    wrap_up();
  end
endmodule
